// ### deep_sleep_io_retention_wake_monitor.sv
`timescale 1ns/1ps
module deep_sleep_io_retention_wake_monitor #(
  parameter int IO_W  = 16,
  parameter int GPR_W = 16
) (
  input wire logic                       clk,
  input wire logic                       rst,
  input wire logic                       ce,
  input wire logic                       sleep_req,
  input wire logic                       wake_event,
  input wire logic                       master_clear_event,
  input wire logic                       brownout_event,
  input wire ds_retention_pkg::ds_cfg_t  cfg,
  input wire logic                       sw_clr_release,
  input wire logic                       sw_clr_flag,
  input wire logic                       sw_wr_gpr,
  input wire logic [IO_W-1:0]            pin_out,
  input wire logic [IO_W-1:0]            pin_oe,
  input wire logic                       release_bit,
  input wire logic                       asleep,
  input wire logic                       wdt_wake,
  input wire logic [15:0]                reset_control_reg,
  input wire logic [GPR_W-1:0]           retention_general_regs0,
  input wire logic [GPR_W-1:0]           retention_general_regs1
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  // recent master clear history: pins legally jump to reset state then
  logic [5:0] master_clear_sh_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      master_clear_sh_reg <= 6'h00;
    end else begin
      master_clear_sh_reg <= {master_clear_sh_reg[4:0], master_clear_event};
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_entry_sets_hold: assert property ($rose(asleep) |-> release_bit && reset_control_reg[10])
    else $error("sleep entry without hold or flag");
  a_flag_holds: assert property (reset_control_reg[10] && !sw_clr_flag |=> reset_control_reg[10])
    else $error("deep sleep flag dropped by itself");
  a_flag_clears: assert property (sw_clr_flag && ce && !sleep_req && !$past(sleep_req) && !asleep
    |=> !reset_control_reg[10])
    else $error("deep sleep flag not cleared");
  a_release_holds: assert property (release_bit && !sw_clr_release && !cfg.brownout_en
    |=> release_bit)
    else $error("hold released without a clear");
  a_pins_frozen: assert property (release_bit && $past(release_bit) && !cfg.brownout_en
    && master_clear_sh_reg == 6'h00 && !master_clear_event |-> $stable(pin_out) && $stable(pin_oe))
    else $error("held pins changed");
  a_master_clear_pins_reset: assert property ($rose(master_clear_event) && asleep && ce
    |-> ##[3:8] (pin_oe == '0))
    else $error("pins not reset on master clear");
  a_master_clear_keeps_hold: assert property ($rose(master_clear_event) && asleep && !cfg.brownout_en
    |-> ##1 release_bit [*8])
    else $error("hold lost on master clear");
  a_lose_state: assert property ($rose(brownout_event) && asleep && cfg.brownout_en && ce
    |-> ##[3:8] (!release_bit && retention_general_regs0 == '0
    && retention_general_regs1 == '0))
    else $error("state kept after brownout");
  a_gpr_refused: assert property (asleep && sw_wr_gpr && !cfg.brownout_en
    |=> $stable(retention_general_regs0) && $stable(retention_general_regs1))
    else $error("retention written while asleep");
  a_wdt_pulse: assert property (wdt_wake |=> !wdt_wake)
    else $error("watchdog wake longer than one cycle");
endmodule // deep_sleep_io_retention_wake_monitor

bind deep_sleep_io_retention_wake deep_sleep_io_retention_wake_monitor #(
  .IO_W(IO_W), .GPR_W(GPR_W)) i_mon (
  .clk(clk), .rst(rst), .ce(ce), .sleep_req(sleep_req), .wake_event(wake_event),
  .master_clear_event(master_clear_event), .brownout_event(brownout_event), .cfg(cfg),
  .sw_clr_release(sw_clr_release), .sw_clr_flag(sw_clr_flag), .sw_wr_gpr(sw_wr_gpr),
  .pin_out(pin_out), .pin_oe(pin_oe), .release_bit(release_bit), .asleep(asleep),
  .wdt_wake(wdt_wake), .reset_control_reg(reset_control_reg),
  .retention_general_regs0(retention_general_regs0),
  .retention_general_regs1(retention_general_regs1));

// ### deep_sleep_io_retention_wake_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
`include "ds_retention_cfg.svh"
module deep_sleep_io_retention_wake_tb;
  localparam int MAX_CYC = 20000;  // tests take under 1000 cycles
  localparam int TICK_P  = 4;      // secondary oscillator period in clk cycles
  localparam int S_SLEEP = 0, S_WAKE = 1, S_MASTER_CLEAR = 2, S_BOR = 3, S_PINS = 4, S_OSC = 5;
  localparam int S_REL = 6, S_CLRFLAG = 7, S_GPR = 8, S_CLRPOR = 9, S_POR = 10;
  logic                         clk, rst, ce;
  logic [10:0]                  strobe;     // one-cycle event and firmware lines
  logic [3:0]                   tick_div;   // slow clock divider
  ds_retention_pkg::ds_cfg_t    cfg;
  logic [1:0]                   calendar_source_select;
  ds_retention_pkg::pin_cfg_t   sw_pins, p0, p1;
  logic                         sw_osc_en;
  logic [15:0]                  sw_gpr0, sw_gpr1, g0, g1, pin_in, pin_out, pin_oe, pin_rd;
  logic                         release_bit, sec_osc_enable, secondary_oscillator_running, low_power_rc_osc_running;
  logic                         calendar_tick, asleep, wdt_wake;
  logic [15:0]                  reset_control_reg, retention_general_regs0, retention_general_regs1;
  ds_retention_pkg::wake_kind_t wake_source_reg;
  int                           n_errors, samples_checked, cyc_count, wdt_count, cal_count;
  int unsigned                  seed_init;
  deep_sleep_io_retention_wake i_dut (
    .clk(clk), .rst(rst), .ce(ce), .sleep_req(strobe[S_SLEEP]), .wake_event(strobe[S_WAKE]),
    .master_clear_event(strobe[S_MASTER_CLEAR]), .brownout_event(strobe[S_BOR]), .por_event(strobe[S_POR]),
    .cfg(cfg), .calendar_source_select(calendar_source_select), .low_power_rc_osc_tick(tick_div[2]),
    .secondary_oscillator_tick(tick_div[1]), .sw_wr_pins(strobe[S_PINS]), .sw_pins(sw_pins),
    .sw_wr_osc(strobe[S_OSC]), .sw_osc_en(sw_osc_en), .sw_clr_release(strobe[S_REL]),
    .sw_clr_flag(strobe[S_CLRFLAG]), .sw_wr_gpr(strobe[S_GPR]), .sw_gpr0(sw_gpr0),
    .sw_gpr1(sw_gpr1), .sw_clr_por_flag(strobe[S_CLRPOR]), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_rd(pin_rd), .release_bit(release_bit),
    .sec_osc_enable(sec_osc_enable), .secondary_oscillator_running(secondary_oscillator_running),
    .low_power_rc_osc_running(low_power_rc_osc_running), .calendar_tick(calendar_tick), .asleep(asleep),
    .wdt_wake(wdt_wake), .reset_control_reg(reset_control_reg),
    .retention_general_regs0(retention_general_regs0),
    .retention_general_regs1(retention_general_regs1), .wake_source_reg(wake_source_reg));
  ////////////////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // slow clocks, pulse counters and the run ceiling
  always @(posedge clk) begin
    tick_div  <= tick_div + 4'h1;
    cyc_count <= cyc_count + 1;
    if (wdt_wake) wdt_count <= wdt_count + 1;
    if (calendar_tick) cal_count <= cal_count + 1;
    if (cyc_count >= MAX_CYC) begin
      n_errors++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // expectations from the rules
  function automatic logic [15:0] exp_oe(input ds_retention_pkg::pin_cfg_t p);
    exp_oe = ~p.dir;  // inputs are not driven
  endfunction
  function automatic logic [15:0] exp_rcr(input logic ds, input logic por);
    exp_rcr = 16'h0000;
    exp_rcr[`DS_FLAG_BIT] = ds;
    exp_rcr[`DS_POR_FLAG_BIT] = por;
  endfunction
  function automatic ds_retention_pkg::pin_cfg_t rand_pins();
    rand_pins = {16'($urandom), 16'($urandom)};
  endfunction
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // raise one line for exactly one cycle; a cycle gap follows before the next
  task pulse(input int sel);
    @(posedge clk);
    strobe[sel] <= 1'b1;
    @(posedge clk);
    strobe <= '0;
  endtask
  task enter_sleep;
    pulse(S_SLEEP);
    cyc(3);
    `CHK(release_bit, 1'b1)
    `CHK(reset_control_reg[`DS_FLAG_BIT], 1'b1)
    `CHK(asleep, 1'b1)
  endtask
  // watchdog wake on the secondary oscillator, started by firmware or not
  task run_wdt(input logic osc_first);
    int exp_cyc;
    int seen;
    logic [4:0] ps;
    ps = 5'($urandom % 2);
    @(posedge clk);
    cfg.wdt_enable    <= 1'b1;
    cfg.wdt_clk_sel   <= 1'b0;
    cfg.wdt_postscale <= ps;
    sw_osc_en         <= osc_first;
    pulse(S_OSC);
    cyc(2);
    `CHK(secondary_oscillator_running, osc_first)
    seen = wdt_count;
    exp_cyc = (`DS_WDT_BASE_TICKS << ps) * TICK_P;
    enter_sleep();
    `CHK(secondary_oscillator_running, 1'b1)
    cyc(exp_cyc - 16);
    `CHK(asleep, 1'b1)
    cyc(32);
    `CHK(wdt_count, seen + 1)
    `CHK(wake_source_reg, ds_retention_pkg::WAKE_EVENT)
    pulse(S_REL);
    @(posedge clk);
    cfg.wdt_enable <= 1'b0;
  endtask
  task finish_test;
    $display("checks=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  initial begin
    n_errors = 0;
    samples_checked = 0;
    cyc_count = 0;
    wdt_count = 0;
    cal_count = 0;
    seed_init = $urandom(16);
    tick_div <= 4'h0;
    strobe <= '0;
    ce <= 1'b1;
    rst <= 1'b1;
    cfg <= '0;
    calendar_source_select <= 2'h0;
    sw_pins <= '0;
    sw_osc_en <= 1'b0;
    sw_gpr0 <= 16'h0000;
    sw_gpr1 <= 16'h0000;
    pin_in <= 16'h0000;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    cyc(1);
    `CHK(reset_control_reg, exp_rcr(1'b0, 1'b1))
    `CHK(release_bit, 1'b0)
    // event wake: pins held, new settings wait for release
    p0 = rand_pins();
    p1 = rand_pins();
    g0 = 16'($urandom);
    g1 = 16'($urandom);
    @(posedge clk);
    sw_pins <= p0;
    sw_gpr0 <= g0;
    sw_gpr1 <= g1;
    pulse(S_PINS);
    pulse(S_GPR);
    pulse(S_CLRPOR);
    cyc(3);
    `CHK(pin_oe, exp_oe(p0))
    `CHK(pin_out, p0.lat)
    `CHK(reset_control_reg, exp_rcr(1'b0, 1'b0))
    enter_sleep();
    @(posedge clk);
    sw_pins <= p1;
    sw_gpr0 <= ~g0;
    pulse(S_PINS);
    pulse(S_GPR);
    pulse(S_WAKE);
    cyc(6);
    `CHK(wake_source_reg, ds_retention_pkg::WAKE_EVENT)
    `CHK(reset_control_reg, exp_rcr(1'b1, 1'b1))
    `CHK(pin_oe, exp_oe(p0))
    `CHK(pin_out, p0.lat)
    `CHK(sec_osc_enable, 1'b0)
    pulse(S_PINS);
    @(posedge clk);
    sw_osc_en <= 1'b1;
    pulse(S_OSC);
    cyc(3);
    `CHK(pin_oe, exp_oe(p0))
    `CHK(secondary_oscillator_running, 1'b0)
    pulse(S_REL);
    cyc(3);
    `CHK(pin_oe, exp_oe(p1))
    `CHK(pin_out, p1.lat)
    `CHK(secondary_oscillator_running, 1'b1)
    `CHK(retention_general_regs0, g0)
    pulse(S_CLRFLAG);
    cyc(2);
    `CHK(reset_control_reg[`DS_FLAG_BIT], 1'b0)
    // master clear in sleep
    enter_sleep();
    pulse(S_MASTER_CLEAR);
    cyc(6);
    `CHK(wake_source_reg, ds_retention_pkg::WAKE_MASTER_CLEAR)
    `CHK(release_bit, 1'b1)
    `CHK(pin_oe, 16'h0000)
    `CHK(sec_osc_enable, 1'b1)
    `CHK(retention_general_regs1, g1)
    pulse(S_REL);
    // brownout or power cycle in sleep loses everything
    @(posedge clk);
    cfg.brownout_en <= 1'b1;
    enter_sleep();
    pulse((($urandom % 2) == 0) ? S_BOR : S_POR);
    cyc(6);
    `CHK(release_bit, 1'b0)
    `CHK(retention_general_regs0, 16'h0000)
    `CHK(retention_general_regs1, 16'h0000)
    `CHK(wake_source_reg, ds_retention_pkg::WAKE_POR)
    `CHK(pin_oe, 16'h0000)
    @(posedge clk);
    cfg.brownout_en <= 1'b0;
    // watchdog: auto-started clock, then firmware-started clock
    run_wdt(1'b0);
    run_wdt(1'b1);
    // calendar from the rc oscillator, period 8 cycles, and pad reads
    @(posedge clk);
    calendar_source_select <= 2'h1;
    pin_in <= 16'($urandom);
    cyc(8);
    `CHK(low_power_rc_osc_running, 1'b1)
    `CHK(pin_rd, pin_in)
    cal_count = 0;
    cyc(64);
    `CHK((cal_count >= 7) && (cal_count <= 9), 1'b1)
    finish_test();
  end
endmodule // deep_sleep_io_retention_wake_tb

// ### ds_retention_cfg.svh
`ifndef DS_RETENTION_CFG_SVH
`define DS_RETENTION_CFG_SVH
// io port width and retention register width
`define DS_IO_WIDTH        16
`define DS_GPR_WIDTH       16
// bit of the deep-sleep flag in the reset control word
`define DS_FLAG_BIT        10
// bit of the power-on flag and reset value of the reset control word
`define DS_POR_FLAG_BIT    0
`define DS_RCR_RESET       16'h0001
// postscale field width and extremes
`define DS_PS_WIDTH        5
`define DS_TIMEOUT_MIN_MS  1
`define DS_TIMEOUT_MAX_DAY 25.7
// calendar source select codes
`define DS_CAL_SEL_LOW_POWER_RC_OSC    2'h1
`define DS_CAL_SEL_SECONDARY_OSCILLATOR    2'h0
// oscillator start-up cycles (arbitrary default)
`define DS_OSC_START_CYC   8'h10
// watchdog base tick divisor: 1 ms at 32 kHz ~ 32 ticks
`define DS_WDT_BASE_TICKS  32'h0000_0020
`endif

// ### ds_retention_pkg.sv
package ds_retention_pkg;
  // reset source classification on wake
  typedef enum logic [1:0] {
    WAKE_NONE   = 2'b00,
    WAKE_EVENT  = 2'b01,
    WAKE_MASTER_CLEAR   = 2'b10,
    WAKE_POR    = 2'b11
  } wake_kind_t;
  // configuration word fields
  typedef struct packed {
    logic       wdt_enable;
    logic       wdt_clk_sel;   // 1: low_power_rc_osc, 0: secondary oscillator
    logic [4:0] wdt_postscale;
    logic       brownout_en;
  } ds_cfg_t;
  // pin drive bundle
  typedef struct packed {
    logic [15:0] dir;   // 1 = input
    logic [15:0] lat;
  } pin_cfg_t;
endpackage

// ### ds_retention_wake.sv
`timescale 1ns/1ps
`include "ds_retention_cfg.svh"
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - pins keep pre-wake state after event or watchdog wake
// - held inputs stay hi-z, outputs drive
// - wake resets direction, latch, oscillator enable
// - new settings reach pins after release
// - brownout/por in sleep releases, clears retention
// - master clear keeps retention, release, oscillator
// - watchdog own enable, independent of main
// - sleep entry resets watchdog counter
// - clock select bit, five-bit postscale
// - calendar/watchdog from secondary or low_power_rc_osc
// - watchdog auto-starts its stopped clock
// - flag set on entry, software clears
// - true por resets all deep-sleep logic
module deep_sleep_io_retention_wake #(
  parameter int IO_W  = `DS_IO_WIDTH,
  parameter int GPR_W = `DS_GPR_WIDTH
) (
  input  wire logic                       clk,
  input  wire logic                       rst,          // true power-on reset
  input  wire logic                       ce,
  input  wire logic                       sleep_req,    // firmware enters deep sleep
  input  wire logic                       wake_event,   // async wake source pin
  input  wire logic                       master_clear_event,   // async master clear pin
  input  wire logic                       brownout_event,
  input  wire logic                       por_event,    // power cycle while asleep
  input  wire ds_retention_pkg::ds_cfg_t  cfg,          // configuration word
  input  wire logic [1:0]                 calendar_source_select,
  input  wire logic                       low_power_rc_osc_tick,    // async low-power rc clock
  input  wire logic                       secondary_oscillator_tick,    // async secondary osc clock
  input  wire logic                       sw_wr_pins,
  input  wire ds_retention_pkg::pin_cfg_t sw_pins,
  input  wire logic                       sw_wr_osc,
  input  wire logic                       sw_osc_en,
  input  wire logic                       sw_clr_release,
  input  wire logic                       sw_clr_flag,
  input  wire logic                       sw_wr_gpr,
  input  wire logic [GPR_W-1:0]           sw_gpr0,
  input  wire logic [GPR_W-1:0]           sw_gpr1,
  input  wire logic                       sw_clr_por_flag,
  input  wire logic [IO_W-1:0]            pin_in,       // async pad inputs
  output logic [IO_W-1:0]                 pin_out,
  output logic [IO_W-1:0]                 pin_oe,
  output logic [IO_W-1:0]                 pin_rd,
  output logic                            release_bit,
  output logic                            sec_osc_enable,
  output logic                            secondary_oscillator_running,
  output logic                            low_power_rc_osc_running,
  output logic                            calendar_tick,
  output logic                            asleep,
  output logic                            wdt_wake,
  output logic [15:0]                     reset_control_reg,
  output logic [GPR_W-1:0]                retention_general_regs0,
  output logic [GPR_W-1:0]                retention_general_regs1,
  output ds_retention_pkg::wake_kind_t    wake_source_reg
);
  ////////////////////////////////////////////////////////////////////////////
  // state machine
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_SLEEP = 2'b01,
    ST_WAKE  = 2'b10
  } ds_state_t;
  ds_state_t state_reg;

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers for every asynchronous input
  logic [4:0]      async_s1, async_s2;     // wake, master_clear, bor, por, low_power_rc_osc
  logic            secondary_oscillator_s1, secondary_oscillator_s2;
  logic [IO_W-1:0] pin_s1, pin_s2;
  logic            low_power_rc_osc_d, secondary_oscillator_d;         // edge detect of second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      async_s1 <= 5'h00;
      async_s2 <= 5'h00;
      secondary_oscillator_s1  <= 1'b0;
      secondary_oscillator_s2  <= 1'b0;
      pin_s1   <= '0;
      pin_s2   <= '0;
      low_power_rc_osc_d   <= 1'b0;
      secondary_oscillator_d   <= 1'b0;
    end else if (ce) begin
      async_s1 <= {low_power_rc_osc_tick, por_event, brownout_event, master_clear_event, wake_event};
      async_s2 <= async_s1;
      secondary_oscillator_s1  <= secondary_oscillator_tick;
      secondary_oscillator_s2  <= secondary_oscillator_s1;
      pin_s1   <= pin_in;
      pin_s2   <= pin_s1;
      low_power_rc_osc_d   <= async_s2[4];
      secondary_oscillator_d   <= secondary_oscillator_s2;
    end
  end
  logic wake_s, master_clear_s, bor_s, por_s, low_power_rc_osc_edge, secondary_oscillator_edge;
  assign wake_s    = async_s2[0];
  assign master_clear_s    = async_s2[1];
  assign bor_s     = async_s2[2];
  assign por_s     = async_s2[3];
  assign low_power_rc_osc_edge = async_s2[4] & ~low_power_rc_osc_d & low_power_rc_osc_running;
  assign secondary_oscillator_edge = secondary_oscillator_s2 & ~secondary_oscillator_d & secondary_oscillator_running;

  ////////////////////////////////////////////////////////////////////////////
  // software pin config, held frozen copy, and retention registers
  ds_retention_pkg::pin_cfg_t cfg_reg, held_reg;
  logic lose_state;  // deep-sleep brownout or power cycle while asleep
  logic sleep_entry;
  logic wdt_timeout;
  assign lose_state  = (state_reg == ST_SLEEP) && cfg.brownout_en && (bor_s || por_s);
  assign sleep_entry = (state_reg == ST_RUN) && sleep_req;

  // pin config written by firmware; wake returns it to reset values
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_reg <= '{dir: '1, lat: '0};
    end else if (ce) begin
      if (state_reg == ST_SLEEP && (wake_s || master_clear_s || lose_state || wdt_timeout)) begin
        cfg_reg <= '{dir: '1, lat: '0};
      end else if (sw_wr_pins && state_reg != ST_SLEEP) begin
        cfg_reg <= sw_pins;
      end
    end
  end

  // frozen pin image captured at entry; master clear forces reset state
  always_ff @(posedge clk) begin
    if (rst) begin
      held_reg <= '{dir: '1, lat: '0};
    end else if (ce) begin
      if (sleep_entry && !release_bit) begin
        // a re-entry while still held keeps the old image: unreleased writes never reach pins
        held_reg <= cfg_reg;
      end else if (state_reg == ST_SLEEP && master_clear_s && !lose_state) begin
        held_reg <= '{dir: '1, lat: '0};
      end
    end
  end

  // release bit: set on entry, cleared by firmware or state loss
  always_ff @(posedge clk) begin
    if (rst) begin
      release_bit <= 1'b0;
    end else if (ce) begin
      if (sleep_entry) begin
        release_bit <= 1'b1;
      end else if (lose_state) begin
        release_bit <= 1'b0;
      end else if (sw_clr_release && state_reg != ST_SLEEP) begin
        release_bit <= 1'b0;
      end
    end
  end

  // pin drivers: held image while release set, live config otherwise
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_out <= '0;
      pin_oe  <= '0;
      pin_rd  <= '0;
    end else if (ce) begin
      if (release_bit && !lose_state) begin
        pin_out <= held_reg.lat;
        pin_oe  <= ~held_reg.dir;
      end else begin
        pin_out <= cfg_reg.lat;
        pin_oe  <= ~cfg_reg.dir;
      end
      pin_rd <= pin_s2;
    end
  end

  // retention general registers survive master clear, not brownout
  always_ff @(posedge clk) begin
    if (rst) begin
      retention_general_regs0 <= '0;
      retention_general_regs1 <= '0;
    end else if (ce) begin
      if (lose_state) begin
        retention_general_regs0 <= '0;
        retention_general_regs1 <= '0;
      end else if (sw_wr_gpr && state_reg == ST_RUN) begin
        retention_general_regs0 <= sw_gpr0;
        retention_general_regs1 <= sw_gpr1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // oscillators: secondary enable and run state
  logic wdt_needs_secondary_oscillator, wdt_needs_low_power_rc_osc;
  assign wdt_needs_secondary_oscillator = cfg.wdt_enable && !cfg.wdt_clk_sel;
  assign wdt_needs_low_power_rc_osc = cfg.wdt_enable &&  cfg.wdt_clk_sel;

  // enable bit reset on wake unless master clear keeps it
  always_ff @(posedge clk) begin
    if (rst) begin
      sec_osc_enable <= 1'b0;
    end else if (ce) begin
      if (state_reg == ST_SLEEP && (wake_s || lose_state || wdt_timeout) && !master_clear_s) begin
        sec_osc_enable <= 1'b0;
      end else if (sw_wr_osc && state_reg != ST_SLEEP) begin
        // stored while held, takes effect on the oscillator only after release
        sec_osc_enable <= sw_osc_en;
      end
    end
  end

  // oscillator running flags; in sleep the watchdog may start its clock, after wake the state is retained until release
  always_ff @(posedge clk) begin
    if (rst) begin
      secondary_oscillator_running <= 1'b0;
      low_power_rc_osc_running <= 1'b0;
    end else if (ce) begin
      if (state_reg == ST_SLEEP) begin
        secondary_oscillator_running <= secondary_oscillator_running | wdt_needs_secondary_oscillator;
        low_power_rc_osc_running <= low_power_rc_osc_running | wdt_needs_low_power_rc_osc;
      end else if (!release_bit) begin
        secondary_oscillator_running <= sec_osc_enable;
        low_power_rc_osc_running <= wdt_needs_low_power_rc_osc || calendar_source_select == `DS_CAL_SEL_LOW_POWER_RC_OSC;
      end
    end
  end

  // calendar tick from the selected source
  always_ff @(posedge clk) begin
    if (rst) begin
      calendar_tick <= 1'b0;
    end else if (ce) begin
      calendar_tick <= (calendar_source_select == `DS_CAL_SEL_LOW_POWER_RC_OSC) ? low_power_rc_osc_edge : secondary_oscillator_edge;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog: own enable, counts only in sleep
  ds_watchdog u_wdt (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .clear     (sleep_entry),
    .run       (cfg.wdt_enable && state_reg == ST_SLEEP),
    .tick      (cfg.wdt_clk_sel ? low_power_rc_osc_edge : secondary_oscillator_edge),
    .postscale (cfg.wdt_postscale),
    .timeout   (wdt_timeout)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer and wake source
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg       <= ST_RUN;
      wake_source_reg <= ds_retention_pkg::WAKE_NONE;
      wdt_wake        <= 1'b0;
    end else if (ce) begin
      wdt_wake <= 1'b0;
      case (state_reg)
        ST_RUN: begin
          if (sleep_req) begin
            state_reg <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (lose_state) begin
            state_reg       <= ST_WAKE;
            wake_source_reg <= ds_retention_pkg::WAKE_POR;
          end else if (master_clear_s) begin
            state_reg       <= ST_WAKE;
            wake_source_reg <= ds_retention_pkg::WAKE_MASTER_CLEAR;
          end else if (wake_s || wdt_timeout) begin
            state_reg       <= ST_WAKE;
            wake_source_reg <= ds_retention_pkg::WAKE_EVENT;
            wdt_wake        <= wdt_timeout;
          end
        end
        ST_WAKE: begin
          state_reg <= ST_RUN;
        end
        default: begin
          state_reg <= ST_RUN;
        end
      endcase
    end
  end

  // reset control flags; set wins over software clear
  always_ff @(posedge clk) begin
    if (rst) begin
      reset_control_reg <= `DS_RCR_RESET;       // power-on flag set
      asleep            <= 1'b0;
    end else if (ce) begin
      asleep <= (state_reg == ST_SLEEP);
      if (sleep_entry) begin
        reset_control_reg[`DS_FLAG_BIT] <= 1'b1;
      end else if (sw_clr_flag) begin
        reset_control_reg[`DS_FLAG_BIT] <= 1'b0;
      end
      if (state_reg == ST_SLEEP && (wake_s || wdt_timeout || lose_state)) begin
        reset_control_reg[`DS_POR_FLAG_BIT] <= 1'b1;
      end else if (sw_clr_por_flag) begin
        reset_control_reg[`DS_POR_FLAG_BIT] <= 1'b0;
      end
    end
  end
endmodule // deep_sleep_io_retention_wake

// ### ds_watchdog.sv
`timescale 1ns/1ps
`include "ds_retention_cfg.svh"
// deep-sleep watchdog counter, ticked by selected low-speed clock pulse
module ds_watchdog (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     ce,
  input  wire logic                     clear,
  input  wire logic                     run,
  input  wire logic                     tick,
  input  wire logic [`DS_PS_WIDTH-1:0]  postscale,
  output logic                          timeout
);
  logic [47:0] count_reg;  // tick counter
  // timeout ticks: base times two to the postscale
  function automatic logic [47:0] limit(input logic [`DS_PS_WIDTH-1:0] ps);
    limit = 48'(`DS_WDT_BASE_TICKS) << ps;
  endfunction
  // counter: clear wins over counting
  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= 48'h0;
      timeout   <= 1'b0;
    end else if (ce) begin
      if (clear) begin
        count_reg <= 48'h0;
        timeout   <= 1'b0;
      end else if (run && tick && !timeout) begin
        if (count_reg + 48'h1 >= limit(postscale)) begin
          timeout <= 1'b1;
        end
        count_reg <= count_reg + 48'h1;
      end
    end
  end
endmodule // ds_watchdog
